// file: rtl/hsfc_consts.vh
`ifndef HSFC_CONSTS_VH
`define HSFC_CONSTS_VH

// register byte offsets
`define HSFC_OFS_CTRL_STATUS   4'h0
`define HSFC_OFS_LAST_STATUS   4'h4

// control/status word: sticky flags
`define HSFC_FLG_INVALID       0
`define HSFC_FLG_SUBNORMAL     1
`define HSFC_FLG_OVERFLOW      2
`define HSFC_FLG_UNDERFLOW     3
`define HSFC_FLG_PRECISION     4
`define HSFC_FLG_LSB           0
`define HSFC_FLG_MSB           4
// control/status word: masks, same order as the flags
`define HSFC_MSK_LSB           5
`define HSFC_MSK_MSB           9
// control/status word: rounding field and flush-to-zero bit
`define HSFC_RND_LSB           10
`define HSFC_RND_MSB           11
`define HSFC_FTZ_BIT           12
`define HSFC_CTRL_USED_MSB     12

// reset value: all masks set, round to nearest even, nothing flagged
`define HSFC_CTRL_RESET        13'h03E0

// rounding encodings
`define HSFC_RND_NEAREST       2'h0
`define HSFC_RND_DOWN          2'h1
`define HSFC_RND_UP            2'h2
`define HSFC_RND_ZERO          2'h3

// immediate byte fields
`define HSFC_IMM_SRC_BIT       2
`define HSFC_IMM_RND_LSB       0
`define HSFC_IMM_RND_MSB       1

// single and half format constants
`define HSFC_SP_EXP_ONES       8'hFF
`define HSFC_HP_EXP_ONES       5'h1F
`define HSFC_SP_DROP_BITS      14
`define HSFC_EXP_HALF_MIN_N    8'h71
`define HSFC_EXP_HALF_OVF      8'h8F
`define HSFC_EXP_REBIAS        8'h70

// cycles from request to result
`define HSFC_LATENCY           1

`endif

// file: rtl/hsfc_widen_lane.v
`default_nettype none
`include "hsfc_consts.vh"

module hsfc_widen_lane (
	input  wire [15:0] halfIn,
	output reg  [31:0] singleOut,
	output reg         sigNan
);

	reg        sgn;
	reg [4:0]  ex;
	reg [9:0]  fr;
	reg [3:0]  lead;
	reg [9:0]  shifted;
	integer    i;

	always @* begin
		sgn       = halfIn[15];
		ex        = halfIn[14:10];
		fr        = halfIn[9:0];
		lead      = 4'h0;
		shifted   = 10'h000;
		sigNan    = 1'b0;
		singleOut = 32'h00000000;
		for (i = 0; i < 10; i = i + 1) begin
			if (fr[i]) begin
				lead = i[3:0];
			end
		end
		if (ex == `HSFC_HP_EXP_ONES) begin
			if (fr != 10'h000) begin
				// nan comes out quiet, payload kept
				sigNan    = ~fr[9];
				singleOut = {sgn, `HSFC_SP_EXP_ONES, 1'b1, fr[8:0], 13'h0000};
			end else begin
				singleOut = {sgn, `HSFC_SP_EXP_ONES, 23'h000000};
			end
		end else if (ex == 5'h00) begin
			if (fr == 10'h000) begin
				singleOut = {sgn, 31'h00000000};
			end else begin
				// subnormal half is exact in single, no flag raised
				shifted   = fr << (4'hA - lead);
				singleOut = {sgn, 8'h67 + {4'h0, lead}, shifted, 13'h0000};
			end
		end else begin
			singleOut = {sgn, {3'h0, ex} + `HSFC_EXP_REBIAS, fr, 13'h0000};
		end
	end

endmodule // hsfc_widen_lane
`default_nettype wire

// file: rtl/hsfc_converter.v
`default_nettype none
`include "hsfc_consts.vh"

module hsfc_converter #(
	parameter LANES = 4
) (
	input  wire                 clk_sys,
	input  wire                 rst_b,
	input  wire                 opValid,
	input  wire                 opNarrow,
	input  wire [LANES*32-1:0]  opSrc,
	input  wire [7:0]           opImm,
	input  wire [3:0]           regAddr,
	input  wire [31:0]          regWrData,
	input  wire                 regWrEn,
	input  wire                 regRdEn,
	output reg  [31:0]          regRdData_r,
	output reg                  resValid_r,
	output reg                  resFault_r,
	output reg  [LANES*32-1:0]  resData_r,
	output reg  [4:0]           resFlags_r
);

	////////////////////////////////////////////////////////////////////////////////

	function rndInc;
		input [1:0] mode;
		input       sgn;
		input       lsb;
		input       grd;
		input       stk;
		begin
			case (mode)
				`HSFC_RND_NEAREST: rndInc = grd & (stk | lsb);
				`HSFC_RND_DOWN:    rndInc = sgn & (grd | stk);
				`HSFC_RND_UP:      rndInc = ~sgn & (grd | stk);
				`HSFC_RND_ZERO:    rndInc = 1'b0;
				default:           rndInc = 1'b0;
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	reg  [`HSFC_CTRL_USED_MSB:0] ctrl_r;
	reg  [`HSFC_CTRL_USED_MSB:0] ctrl_nxt;
	reg  [4:0]                   lastFlags_r;
	reg                          lastFault_r;

	wire [4:0] maskBits = ctrl_r[`HSFC_MSK_MSB:`HSFC_MSK_LSB];
	wire [1:0] ctrlRnd  = ctrl_r[`HSFC_RND_MSB:`HSFC_RND_LSB];
	// flush-to-zero bit is stored for software but never read by the datapath

	// imm[7:3] never enter the decode
	wire [1:0] rndMode = opImm[`HSFC_IMM_SRC_BIT] ? ctrlRnd :
		opImm[`HSFC_IMM_RND_MSB:`HSFC_IMM_RND_LSB];

	wire [LANES*32-1:0] narrowData;
	wire [LANES*32-1:0] widenData;
	wire [LANES*5-1:0]  narrowFlags;
	wire [LANES*5-1:0]  widenFlags;

	////////////////////////////////////////////////////////////////////////////////
	// narrowing lanes

	genvar g;
	generate
		for (g = 0; g < LANES; g = g + 1) begin : gNarrow
			wire [31:0] f    = opSrc[g*32 +: 32];
			wire        sgn  = f[31];
			wire [7:0]  ex   = f[30:23];
			wire [22:0] fr   = f[22:0];
			wire        isNan  = (ex == `HSFC_SP_EXP_ONES) && (fr != 23'h000000);
			wire        isInf  = (ex == `HSFC_SP_EXP_ONES) && (fr == 23'h000000);
			wire        isZero = (ex == 8'h00) && (fr == 23'h000000);
			wire        isDen  = (ex == 8'h00) && (fr != 23'h000000);
			wire        isSnan = isNan & ~fr[22];
			wire [23:0] sig    = {ex != 8'h00, fr};
			// subnormal result: shift further right, capped so all bits land in sticky
			wire [8:0]  extra  = {1'b0, `HSFC_EXP_HALF_MIN_N} - {1'b0, ex};
			wire [4:0]  amt    = (ex >= `HSFC_EXP_HALF_MIN_N) ? 5'h0D :
				((extra > 9'h00C) ? 5'h19 : (5'h0D + extra[4:0]));
			// one spare low bit so the deepest shift still keeps every bit in sticky
			wire [48:0] wide   = {sig, 25'h0000000} >> amt;
			wire [10:0] kept   = wide[35:25];
			wire        grd    = wide[24];
			wire        stk    = |wide[23:0];
			wire        inexactRaw = grd | stk;
			wire        tiny   = (ex < `HSFC_EXP_HALF_MIN_N) && !isZero;
			wire [7:0]  hexpFull = ex - `HSFC_EXP_REBIAS;
			wire [4:0]  hexp   = (ex >= `HSFC_EXP_HALF_MIN_N) ? hexpFull[4:0] : 5'h00;
			wire        inc    = rndInc(rndMode, sgn, kept[0], grd, stk);
			wire [15:0] sum    = {1'b0, hexp, kept[9:0]} + {15'h0000, inc};
			wire        ovf    = !isNan && !isInf && ((ex >= `HSFC_EXP_HALF_OVF) ||
				(sum[14:10] == `HSFC_HP_EXP_ONES));
			reg  [15:0] half;
			reg  [4:0]  fl;

			always @* begin
				half = 16'h0000;
				fl   = 5'h00;
				if (isNan) begin
					// truncate the low significand bits, keep sign
					half = {sgn, `HSFC_HP_EXP_ONES, fr[22:`HSFC_SP_DROP_BITS - 1]};
					if (isSnan) begin
						half[9] = 1'b1;
						fl[`HSFC_FLG_INVALID] = 1'b1;
					end
				end else if (isInf) begin
					half = {sgn, `HSFC_HP_EXP_ONES, 10'h000};
				end else if (ovf) begin
					half = {sgn, `HSFC_HP_EXP_ONES, 10'h000};
					fl[`HSFC_FLG_OVERFLOW]  = 1'b1;
					fl[`HSFC_FLG_PRECISION] = 1'b1;
				end else begin
					half = {sgn, sum[14:0]};
					fl[`HSFC_FLG_PRECISION] = inexactRaw;
					// unmasked: any tiny result; masked: only when it also loses bits
					fl[`HSFC_FLG_UNDERFLOW] = tiny &
						(~maskBits[`HSFC_FLG_UNDERFLOW] | inexactRaw);
				end
				fl[`HSFC_FLG_SUBNORMAL] = isDen;
			end

			assign narrowData[g*32 +: 32] = {16'h0000, half};
			assign narrowFlags[g*5 +: 5] = fl;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// packing: half results of lanes 2k and 2k+1 fill word k, upper words zero

	reg [LANES*32-1:0] narrowPacked;
	integer k;
	always @* begin
		narrowPacked = {LANES*32{1'b0}};
		for (k = 0; k < LANES; k = k + 1) begin
			narrowPacked[k*16 +: 16] = narrowData[k*32 +: 16];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// widening lanes: half values live in the low half of the operand

	generate
		for (g = 0; g < LANES; g = g + 1) begin : gWiden
			wire [31:0] wOut;
			wire        wSnan;

			hsfc_widen_lane uLane (
				.halfIn    (opSrc[g*16 +: 16]),
				.singleOut (wOut),
				.sigNan    (wSnan)
			);

			assign widenData[g*32 +: 32] = wOut;
			assign widenFlags[g*5 +: 5]  = {4'h0, wSnan};
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// flag combine and fault decision

	reg [4:0]          opFlags;
	reg [LANES*32-1:0] opData;
	integer j;
	always @* begin
		opFlags = 5'h00;
		for (j = 0; j < LANES; j = j + 1) begin
			opFlags = opFlags | (opNarrow ? narrowFlags[j*5 +: 5] :
				widenFlags[j*5 +: 5]);
		end
		opData = opNarrow ? narrowPacked : widenData;
	end

	// any flagged condition whose mask is clear suppresses the result
	wire opFault = |(opFlags & ~maskBits);

	////////////////////////////////////////////////////////////////////////////////
	// result registers

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			resValid_r  <= 1'b0;
			resFault_r  <= 1'b0;
			resData_r   <= {LANES*32{1'b0}};
			resFlags_r  <= 5'h00;
			lastFlags_r <= 5'h00;
			lastFault_r <= 1'b0;
		end else begin
			resValid_r <= opValid;
			if (opValid) begin
				resFault_r  <= opFault;
				resFlags_r  <= opFlags;
				lastFlags_r <= opFlags;
				lastFault_r <= opFault;
				if (!opFault) begin
					resData_r <= opData;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// register port

	always @* begin
		ctrl_nxt = ctrl_r;
		if (regWrEn && regAddr == `HSFC_OFS_CTRL_STATUS) begin
			ctrl_nxt = regWrData[`HSFC_CTRL_USED_MSB:0];
		end
		// a flag raised in the write cycle survives the write
		if (opValid) begin
			ctrl_nxt[`HSFC_FLG_MSB:`HSFC_FLG_LSB] =
				ctrl_nxt[`HSFC_FLG_MSB:`HSFC_FLG_LSB] | opFlags;
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_b) begin
			ctrl_r      <= `HSFC_CTRL_RESET;
			regRdData_r <= 32'h00000000;
		end else begin
			ctrl_r <= ctrl_nxt;
			if (regRdEn) begin
				case (regAddr)
					`HSFC_OFS_CTRL_STATUS: regRdData_r <= {19'h00000, ctrl_r};
					`HSFC_OFS_LAST_STATUS: regRdData_r <= {26'h0000000, lastFault_r,
						lastFlags_r};
					default:               regRdData_r <= 32'h00000000;
				endcase
			end else begin
				regRdData_r <= 32'h00000000;
			end
		end
	end

endmodule // hsfc_converter
`default_nettype wire

// file: testbench/hsfc_checker.sv
`default_nettype none
module hsfc_checker #(
	parameter LANES = 4
) (
	input wire logic			clk_sys,
	input wire logic			rst_b,
	input wire logic			opValid,
	input wire logic			opNarrow,
	input wire logic [LANES*32-1:0]	opSrc,
	input wire logic			regRdEn,
	input wire logic [31:0]		regRdData_r,
	input wire logic			resValid_r,
	input wire logic			resFault_r,
	input wire logic [LANES*32-1:0]	resData_r,
	input wire logic [4:0]		resFlags_r
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	// lane 0 only; flags are ORed so one lane suffices
	wire sNan0 = opSrc[30:23] == 8'hFF && !opSrc[22] && opSrc[21:0] != 22'h0;
	wire sub0 = opSrc[30:23] == 8'h00 && opSrc[22:0] != 23'h0;
	////////////////////////////////////////////////////////////////////////////////
	a_result_one_cycle: assert property (opValid |=> resValid_r)
		else $error("no result after request");
	a_no_stray_result: assert property (!opValid |=> !resValid_r)
		else $error("result without request");
	a_read_idle_zero: assert property (!regRdEn |=> regRdData_r == 32'h0)
		else $error("read data outside read slot");
	a_fault_holds_data: assert property (resValid_r && resFault_r |-> $stable(resData_r))
		else $error("faulting op changed data");
	a_snan_sets_invalid: assert property (opValid && opNarrow && sNan0 |=> resFlags_r[0])
		else $error("signaling nan not flagged");
	a_subnormal_flagged: assert property (opValid && opNarrow && sub0 |=> resFlags_r[1])
		else $error("subnormal source not flagged");
	a_widen_no_subnorm: assert property (opValid && !opNarrow |=> !resFlags_r[1])
		else $error("widening flagged subnormal");
	a_status_stands: assert property (!opValid |=> $stable(resFlags_r) && $stable(resFault_r))
		else $error("status changed while idle");
	a_narrow_upper_zero: assert property (opValid && opNarrow |=>
		resFault_r || resData_r[LANES*32-1:LANES*16] == '0)
		else $error("narrow result upper half not zero");
	c_narrow: cover property (opValid && opNarrow);
	c_widen: cover property (opValid && !opNarrow);
	c_fault: cover property (resValid_r && resFault_r);
endmodule // hsfc_checker
`default_nettype wire

// file: testbench/hsfc_issue_model.sv
`default_nettype none
module hsfc_issue_model #(
	parameter LANES = 4
) (
	input wire logic			clk_sys,
	output var logic			opValid,
	output var logic			opNarrow,
	output var logic [LANES*32-1:0]	opSrc,
	output var logic [7:0]		opImm,
	input wire logic			resValid_r,
	input wire logic			resFault_r,
	input wire logic [LANES*32-1:0]	resData_r,
	input wire logic [4:0]		resFlags_r
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		opValid = 1'b0;
		opNarrow = 1'b0;
		opSrc = '0;
		opImm = 8'h00;
	end
	// released operands are inverted so a stale capture can never pass
	task automatic conv(input logic nar, input logic [LANES*32-1:0] src,
			input logic [7:0] imm, output logic v, output logic [LANES*32-1:0] d,
			output logic [4:0] f, output logic x);
		@(posedge clk_sys);
		opValid <= 1'b1;
		opNarrow <= nar;
		opSrc <= src;
		opImm <= imm;
		@(posedge clk_sys);
		opValid <= 1'b0;
		opNarrow <= ~nar;
		opSrc <= ~src;
		opImm <= ~imm;
		#1;
		v = resValid_r;
		d = resData_r;
		f = resFlags_r;
		x = resFault_r;
	endtask
endmodule // hsfc_issue_model
`default_nettype wire

// file: testbench/testbench.sv
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic		clk_sys;
	logic		rst_b;
	logic		opValid;
	logic		opNarrow;
	logic [127:0]	opSrc;
	logic [7:0]	opImm;
	logic [3:0]	regAddr;
	logic [31:0]	regWrData;
	logic		regWrEn;
	logic		regRdEn;
	logic [31:0]	regRdData_r;
	logic		resValid_r;
	logic		resFault_r;
	logic [127:0]	resData_r;
	logic [4:0]	resFlags_r;
	logic		v;
	logic		x;
	logic [127:0]	d;
	logic [4:0]	f;
	int		tests_run = 0;
	int		n_fail = 0;
	localparam logic [127:0] SRC_R = {32'h3F800000, 32'h3F801800, 32'hBF801000, 32'h3F801000};
	localparam logic [63:0] RND_EXP [4] = '{64'h3C003C01BC003C00, 64'h3C003C00BC013C00,
		64'h3C003C01BC003C01, 64'h3C003C00BC003C00};
	localparam logic [127:0] SRC_T = {32'h38000000, 32'h3F800000, 32'h38000000, 32'h3F800000};
	hsfc_converter #(.LANES(4)) hsfc_converter_i (.clk_sys(clk_sys), .rst_b(rst_b),
		.opValid(opValid), .opNarrow(opNarrow), .opSrc(opSrc), .opImm(opImm),
		.regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regRdData_r(regRdData_r), .resValid_r(resValid_r), .resFault_r(resFault_r),
		.resData_r(resData_r), .resFlags_r(resFlags_r));
	hsfc_issue_model #(.LANES(4)) hsfc_issue_model_i (.clk_sys(clk_sys), .opValid(opValid),
		.opNarrow(opNarrow), .opSrc(opSrc), .opImm(opImm), .resValid_r(resValid_r),
		.resFault_r(resFault_r), .resData_r(resData_r), .resFlags_r(resFlags_r));
	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [3:0] a, input logic [31:0] w);
		@(posedge clk_sys);
		regAddr <= a;
		regWrData <= w;
		regWrEn <= 1'b1;
		@(posedge clk_sys);
		regWrEn <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk_sys);
		regRdEn <= 1'b0;
		#1;
		`CHK(regRdData_r, e)
	endtask
	task automatic cv(input logic n, input logic [127:0] s, input logic [7:0] i,
			input logic [127:0] ed, input logic [4:0] ef, input logic ex);
		hsfc_issue_model_i.conv(n, s, i, v, d, f, x);
		`CHK(v, 1'b1)
		`CHK(x, ex)
		`CHK(f, ef)
		`CHK(d, ed)
	endtask
	task automatic tally_and_finish;
		$display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		rd(4'h0, 32'h000003E0);
		rd(4'h4, 32'h00000000);
		rd(4'h8, 32'h00000000);
		$display("test regs done");
	endtask
	task automatic t_nan;
		cv(1'b1, {64'h3F8000003F800000, 32'h7FC00001, 32'hFF800100}, 8'h00,
			{64'h0, 64'h3C003C007E00FE00}, 5'h01, 1'b0);
		rd(4'h0, 32'h000003E1);
		wr(4'h0, 32'h000003C0);
		cv(1'b1, {64'h4000000040000000, 32'h7FC00001, 32'hFF800100}, 8'h00,
			{64'h0, 64'h3C003C007E00FE00}, 5'h01, 1'b1);
		rd(4'h4, 32'h00000021);
		cv(1'b1, {96'h3F8000003F8000003F800000, 32'h7FC00001}, 8'h00,
			{64'h0, 64'h3C003C003C007E00}, 5'h00, 1'b0);
		wr(4'h0, 32'h000003E0);
		$display("test nan done");
	endtask
	task automatic t_round;
		for (int m = 0; m < 4; m++) begin
			cv(1'b1, SRC_R, {5'h1F, 1'b0, m[1:0]}, {64'h0, RND_EXP[m]}, 5'h10, 1'b0);
		end
		wr(4'h0, 32'h00000BE0);
		cv(1'b1, SRC_R, 8'h04, {64'h0, RND_EXP[2]}, 5'h10, 1'b0);
		wr(4'h0, 32'h000003E0);
		$display("test round done");
	endtask
	task automatic t_range;
		cv(1'b1, {32'h47800000, 32'hC7800000, 32'h33000000, 32'h00000001}, 8'h00,
			{64'h0, 64'h7C00FC0000000000}, 5'h1E, 1'b0);
		wr(4'h0, 32'h000013E0);
		cv(1'b1, SRC_T, 8'h00, {64'h0, 64'h02003C0002003C00}, 5'h00, 1'b0);
		wr(4'h0, 32'h000002E0);
		cv(1'b1, SRC_T, 8'h00, {64'h0, 64'h02003C0002003C00}, 5'h08, 1'b1);
		wr(4'h0, 32'h000003E0);
		$display("test range done");
	endtask
	task automatic t_widen;
		cv(1'b0, {64'h0, 64'h00017E00C0003C00}, 8'h00,
			{128'h338000007FC00000C00000003F800000}, 5'h00, 1'b0);
		cv(1'b0, {64'h0, 64'h3C003C003C007C01}, 8'h00,
			{128'h3F8000003F8000003F8000007FC02000}, 5'h01, 1'b0);
		$display("test widen done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	initial begin
		rst_b = 1'b0;
		regAddr = 4'h0;
		regWrData = 32'h0;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		t_regs();
		t_nan();
		t_round();
		t_range();
		t_widen();
		tally_and_finish();
	end
	// hang guard
	initial begin
		repeat (5000) @(posedge clk_sys);
		n_fail++;
		tally_and_finish();
	end
endmodule // testbench
bind hsfc_converter hsfc_checker #(.LANES(LANES)) hsfc_checker_i (.clk_sys(clk_sys),
	.rst_b(rst_b), .opValid(opValid), .opNarrow(opNarrow), .opSrc(opSrc), .regRdEn(regRdEn),
	.regRdData_r(regRdData_r), .resValid_r(resValid_r), .resFault_r(resFault_r),
	.resData_r(resData_r), .resFlags_r(resFlags_r));
`default_nettype wire
